// >>> hdl/rse_encoder.v
/*
 * Streaming systematic Reed-Solomon encoder with an output FIFO.
 * Holds rse_fifo (shift-register buffer) and rse_encoder (top).
 * Assumes the message source and the codeword consumer are logic on
 * sys_clk, and that the source keeps its own framing and spacing.
 */
// How it works
// [R01] Checks are remainder of shifted message by g
// [R02] Every register updates on rising sys_clk only
// [R03] Active-high synchronous reset, held one period
// [R04] Source marks first symbol, then streams rest
// [R05] Source leaves 2T idle cycles between messages
// [R06] Low clock enable freezes the encoder state; the FIFO keeps draining
// [R07] Stall ignores load and din and holds the direct out_ outputs
// [R08] Start output rises two enabled cycles after marker
// [R09] Output valid high for exactly B cycles
// [R10] Start and end flags pulse one cycle each
// [R11] Minimum spacing gives back-to-back codewords
// [R12] Check symbols leave most significant first
// [R13] Idle with counter zero until marker
// [R14] Message state runs dividing LFSR B-2T cycles
// [R15] LFSR taps are generator coefficients by power
// [R16] Check state shifts registers out for 2T
// [R17] At B-1 go idle or restart message
// [R18] Optional feedback gating needs 2T flush cycles
// [R19] Reset clears checks, counter, state and flags
`timescale 1ns/1ps
`include "rse_defines.vh"

// ----------------------------------------------------------------
// Shift-register FIFO; the head word is always entry zero
// ----------------------------------------------------------------
module rse_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = `RSE_FIFO_DEPTH
)(
    input  wire             clk,
    input  wire             reset,
    input  wire             s_valid,
    output wire             s_ready,
    input  wire [WIDTH-1:0] s_data,
    output wire             m_valid,
    input  wire             m_ready,
    output wire [WIDTH-1:0] m_data
);

    localparam CW = $clog2(DEPTH + 1);
    localparam [CW-1:0] FULL = DEPTH;
    localparam [CW-1:0] ONE  = 1;

    reg  [DEPTH*WIDTH-1:0] mem_q;
    reg  [DEPTH*WIDTH-1:0] mem_d;
    reg  [CW-1:0]          count_q;
    reg  [CW-1:0]          count_d;
    reg  [CW-1:0]          wr_idx;
    reg                    valid_q;
    reg                    ready_q;

    wire push = s_valid & ready_q;
    wire pop  = valid_q & m_ready;

    // Head sits in a fixed slot so the output is a plain flop
    always @* begin
        mem_d   = mem_q;
        count_d = count_q;
        wr_idx  = count_q;
        if (pop) begin
            mem_d = {{WIDTH{1'b0}}, mem_q[DEPTH*WIDTH-1:WIDTH]};
            wr_idx = count_q - ONE;
        end
        if (push) begin
            mem_d[wr_idx*WIDTH +: WIDTH] = s_data;
        end
        if (push && !pop) begin
            count_d = count_q + ONE;
        end else if (pop && !push) begin
            count_d = count_q - ONE;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            mem_q   <= {DEPTH*WIDTH{1'b0}};
            count_q <= {CW{1'b0}};
            valid_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            mem_q   <= mem_d;
            count_q <= count_d;
            valid_q <= (count_d != {CW{1'b0}});
            ready_q <= (count_d != FULL);
        end
    end

    assign s_ready = ready_q;
    assign m_valid = valid_q;
    assign m_data  = mem_q[WIDTH-1:0];

endmodule

// ----------------------------------------------------------------
// Encoder top
// ----------------------------------------------------------------
module rse_encoder #(
    parameter WIDTH      = `RSE_SYM_WIDTH,
    parameter B          = `RSE_BLOCK_LEN,
    parameter T          = `RSE_T,
    parameter PRIM       = `RSE_PRIM_POLY,
    parameter FIRST_ROOT = `RSE_FIRST_ROOT,
    parameter FIFO_DEPTH = `RSE_FIFO_DEPTH
)(
    input  wire             sys_clk,
    input  wire             reset,
    input  wire             clocken,
    input  wire             load,
    input  wire [WIDTH-1:0] din,
    output wire             in_ready,
    output wire             out_valid,
    output wire             out_start,
    output wire             out_end,
    output wire [WIDTH-1:0] out_data,
    output wire             buf_valid,
    input  wire             buf_ready,
    output wire             buf_start,
    output wire             buf_end,
    output wire [WIDTH-1:0] buf_data
);

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam NCHK  = 2 * T;
    localparam CNT_W = $clog2(B);

    localparam [CNT_W-1:0] CNT_ZERO      = `RSE_CNT_RST;
    localparam [CNT_W-1:0] CNT_ONE       = 1;
    localparam [CNT_W-1:0] CNT_LAST_DATA = B - NCHK - 1;
    localparam [CNT_W-1:0] CNT_LAST      = B - 1;

    localparam [1:0] ST_IDLE = `RSE_ST_IDLE;
    localparam [1:0] ST_DATA = `RSE_ST_DATA;
    localparam [1:0] ST_CODE = `RSE_ST_CODE;

    // ------------------------------------------------------------
    // Field arithmetic
    // ------------------------------------------------------------
    // Shift-and-add product reduced by the primitive polynomial
    function [WIDTH-1:0] gf_mul;
        input [WIDTH-1:0] a;
        input [WIDTH-1:0] b;
        reg   [WIDTH-1:0] r;
        reg   [WIDTH:0]   p;
        integer           i;
        begin
            p = PRIM;
            r = {WIDTH{1'b0}};
            for (i = WIDTH - 1; i >= 0; i = i - 1) begin
                r = {r[WIDTH-2:0], 1'b0} ^
                    (r[WIDTH-1] ? p[WIDTH-1:0] : {WIDTH{1'b0}});
                if (b[i]) begin
                    r = r ^ a;
                end
            end
            gf_mul = r;
        end
    endfunction

    // Expanded g(x) = product of (x + alpha^(root+i)), i < 2T.
    // The monic top term is implied and not returned.
    function [NCHK*WIDTH-1:0] gen_poly;
        input integer root;
        reg   [(NCHK+1)*WIDTH-1:0] c;
        reg   [WIDTH-1:0]          r;
        reg   [WIDTH-1:0]          alpha;
        integer                    i;
        integer                    j;
        begin
            alpha = {{(WIDTH-2){1'b0}}, 2'b10};
            r = {{(WIDTH-1){1'b0}}, 1'b1};
            for (i = 0; i < root; i = i + 1) begin
                r = gf_mul(r, alpha);
            end
            c = {(NCHK+1)*WIDTH{1'b0}};
            c[WIDTH-1:0] = {{(WIDTH-1){1'b0}}, 1'b1};
            for (i = 0; i < NCHK; i = i + 1) begin
                for (j = i + 1; j >= 1; j = j - 1) begin
                    c[j*WIDTH +: WIDTH] = c[(j-1)*WIDTH +: WIDTH] ^
                        gf_mul(c[j*WIDTH +: WIDTH], r);
                end
                c[WIDTH-1:0] = gf_mul(c[WIDTH-1:0], r);
                r = gf_mul(r, alpha);
            end
            gen_poly = c[NCHK*WIDTH-1:0];
        end
    endfunction

    // Folded to constants; each tap becomes a fixed XOR network
    localparam [NCHK*WIDTH-1:0] GEN = gen_poly(FIRST_ROOT); // [R15]

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [1:0]            state_q;
    reg  [1:0]            state_d;
    reg  [CNT_W-1:0]      cnt_q;
    reg  [CNT_W-1:0]      cnt_d;
    reg  [WIDTH-1:0]      din_q;
    reg  [NCHK*WIDTH-1:0] chk_q;
    reg  [NCHK*WIDTH-1:0] chk_d;
    reg                   valid_q;
    reg                   start_q;
    reg                   end_q;
    reg  [WIDTH-1:0]      data_q;
    integer               k;

    wire                  fifo_ready;
    wire [WIDTH+1:0]      fifo_out;

    // A full buffer stalls the encoder exactly like a low enable
    wire en = clocken & fifo_ready; // [R06]

    wire [WIDTH-1:0] chk_top = chk_q[NCHK*WIDTH-1 -: WIDTH];
    wire [WIDTH-1:0] fb      = din_q ^ chk_top;

    wire [NCHK*WIDTH-1:0] chk_shift =
        {chk_q[(NCHK-1)*WIDTH-1:0], {WIDTH{1'b0}}};

    // ------------------------------------------------------------
    // Controller
    // ------------------------------------------------------------
    // State and count describe the symbol now held in din_q
    always @* begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ST_IDLE: begin
                cnt_d = CNT_ZERO; // [R13]
                if (load) begin
                    state_d = ST_DATA; // [R14]
                end
            end
            ST_DATA: begin
                cnt_d = cnt_q + CNT_ONE;
                if (cnt_q == CNT_LAST_DATA) begin
                    state_d = ST_CODE; // [R16]
                end
            end
            ST_CODE: begin
                if (cnt_q == CNT_LAST) begin
                    cnt_d   = CNT_ZERO;
                    state_d = load ? ST_DATA : ST_IDLE; // [R17] [R11]
                end else begin
                    cnt_d = cnt_q + CNT_ONE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d   = CNT_ZERO;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Check register datapath
    // ------------------------------------------------------------
    // Explicit mux between divide and shift, so no flush is needed
    // after reset; the gated-feedback variant is not used. [R18]
    always @* begin
        chk_d = chk_q;
        k = 0;
        if (state_q == ST_DATA) begin
            for (k = 0; k < NCHK; k = k + 1) begin
                chk_d[k*WIDTH +: WIDTH] = chk_shift[k*WIDTH +: WIDTH] ^
                    gf_mul(GEN[k*WIDTH +: WIDTH], fb); // [R01] [R14]
            end
        end else if (state_q == ST_CODE) begin
            // Zeros shift in, leaving a clean LFSR for the next block
            chk_d = chk_shift; // [R16]
        end
    end

    // ------------------------------------------------------------
    // Sequential state
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin // [R02]
        if (reset) begin // [R03] [R19]
            state_q <= ST_IDLE;
            cnt_q   <= CNT_ZERO;
            din_q   <= {WIDTH{1'b0}};
            chk_q   <= {NCHK*WIDTH{1'b0}};
        end else if (en) begin // [R06] [R07]
            state_q <= state_d;
            cnt_q   <= cnt_d;
            din_q   <= din;
            chk_q   <= chk_d;
        end
    end

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    // Second pipeline stage: marker to start flag is two enabled
    // edges, every stall cycle adds one.
    always @(posedge sys_clk) begin
        if (reset) begin // [R19]
            valid_q <= 1'b0;
            start_q <= 1'b0;
            end_q   <= 1'b0;
            data_q  <= {WIDTH{1'b0}};
        end else if (en) begin // [R07]
            case (state_q)
                ST_DATA: begin
                    valid_q <= 1'b1; // [R09]
                    start_q <= (cnt_q == CNT_ZERO); // [R08] [R10]
                    end_q   <= 1'b0;
                    data_q  <= din_q; // [R01]
                end
                ST_CODE: begin
                    valid_q <= 1'b1; // [R09]
                    start_q <= 1'b0;
                    end_q   <= (cnt_q == CNT_LAST); // [R10]
                    data_q  <= chk_top; // [R12]
                end
                default: begin
                    valid_q <= 1'b0;
                    start_q <= 1'b0;
                    end_q   <= 1'b0;
                end
            endcase
        end
    end

    assign out_valid = valid_q;
    assign out_start = start_q;
    assign out_end   = end_q;
    assign out_data  = data_q;

    // ------------------------------------------------------------
    // Codeword buffer
    // ------------------------------------------------------------
    // Each symbol is captured at the enabled edge ending its cycle
    rse_fifo #(
        .WIDTH (WIDTH + 2),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk     (sys_clk),
        .reset   (reset),
        .s_valid (en & valid_q),
        .s_ready (fifo_ready),
        .s_data  ({start_q, end_q, data_q}),
        .m_valid (buf_valid),
        .m_ready (buf_ready),
        .m_data  (fifo_out)
    );

    assign in_ready  = fifo_ready;
    assign buf_start = fifo_out[WIDTH+1];
    assign buf_end   = fifo_out[WIDTH];
    assign buf_data  = fifo_out[WIDTH-1:0];

endmodule

// >>> shared/rse_defines.vh
/*
 * Constants for the streaming Reed-Solomon encoder: code shape, field,
 * buffer depth and controller state codes.
 * Assumes it is included by bare name from the design file.
 */
`ifndef RSE_DEFINES_VH
`define RSE_DEFINES_VH

// ----------------------------------------------------------------
// Code shape
// ----------------------------------------------------------------
`define RSE_SYM_WIDTH   8
`define RSE_BLOCK_LEN   160
`define RSE_T           16

// ----------------------------------------------------------------
// Field: primitive polynomial and first generator root power
// ----------------------------------------------------------------
`define RSE_PRIM_POLY   9'h11d
`define RSE_FIRST_ROOT  0

// ----------------------------------------------------------------
// Buffering
// ----------------------------------------------------------------
`define RSE_FIFO_DEPTH  16

// ----------------------------------------------------------------
// Controller states and reset values
// ----------------------------------------------------------------
`define RSE_ST_IDLE     2'h0
`define RSE_ST_DATA     2'h1
`define RSE_ST_CODE     2'h2
`define RSE_CNT_RST     0

`endif

// >>> tb/rse_encoder_properties.sv
/*
 * Port-level checker for rse_encoder, bound into every instance.
 * Assumes a single sys_clk domain and the active-high sync reset.
 */
`timescale 1ns/1ps
module rse_chk #(
    parameter WIDTH = 8,
    parameter B     = 160
)(
    input wire             sys_clk,
    input wire             reset,
    input wire             clocken,
    input wire             load,
    input wire [WIDTH-1:0] din,
    input wire             in_ready,
    input wire             out_valid,
    input wire             out_start,
    input wire             out_end,
    input wire [WIDTH-1:0] out_data,
    input wire             buf_valid,
    input wire             buf_ready,
    input wire             buf_start,
    input wire             buf_end,
    input wire [WIDTH-1:0] buf_data
);
    // ------------------------------------------------------------
    // Symbol index within the codeword, counted on enabled edges
    // ------------------------------------------------------------
    wire        en_w = clocken & in_ready;
    reg  [15:0] idx_q;
    always @(posedge sys_clk) begin
        if (reset)
            idx_q <= 16'h0000;
        else if (en_w && out_valid)
            idx_q <= out_end ? 16'h0000 : idx_q + 16'h0001;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_start_latency: assert property (
        en_w && load ##1 en_w |=> out_start)
        else $error("start flag late or missing");
    a_start_first: assert property (
        out_valid |-> out_start == (idx_q == 0))
        else $error("start flag off first symbol");
    a_end_last: assert property (
        out_valid |-> out_end == (idx_q == B - 1))
        else $error("end flag off last symbol");
    a_start_once: assert property (en_w && out_start |=> !out_start)
        else $error("start flag too long");
    a_end_once: assert property (en_w && out_end |=> !out_end)
        else $error("end flag too long");
    a_stall_hold: assert property (!en_w |=>
        $stable({out_valid, out_start, out_end, out_data}))
        else $error("outputs moved during stall");
    a_idle_quiet: assert property (
        !out_valid |-> !out_start && !out_end)
        else $error("flag without valid");
    a_buf_hold: assert property (buf_valid && !buf_ready |=>
        buf_valid && $stable({buf_start, buf_end, buf_data}))
        else $error("buffer head changed before pop");
    a_reset_clear: assert property (disable iff (1'b0)
        reset |=> !out_valid && !out_start && !out_end && !buf_valid)
        else $error("outputs not cleared by reset");
    c_back2back: cover property (en_w && out_end ##1 out_start);
    c_stall_mid: cover property (out_valid && !clocken);
    c_buf_full: cover property (!in_ready && buf_valid);
endmodule
bind rse_encoder rse_chk #(.WIDTH(WIDTH), .B(B)) chk_u (
    .sys_clk(sys_clk), .reset(reset), .clocken(clocken), .load(load),
    .din(din), .in_ready(in_ready), .out_valid(out_valid),
    .out_start(out_start), .out_end(out_end), .out_data(out_data),
    .buf_valid(buf_valid), .buf_ready(buf_ready), .buf_start(buf_start),
    .buf_end(buf_end), .buf_data(buf_data));

// >>> tb/rse_sink.sv
/*
 * Codeword consumer model: takes buffer words, stalling at random.
 * Assumes the bench seeds $urandom; slow_pct is the stall chance.
 */
`timescale 1ns/1ps
module rse_sink (
    input  wire       sys_clk,
    input  wire [6:0] slow_pct,
    output logic      buf_ready = 1'b0
);
    always @(posedge sys_clk) begin
        buf_ready <= ($urandom % 100) >= slow_pct;
    end
endmodule

// >>> tb/tb_top.sv
/*
 * Self-checking bench: random messages in, model codewords compared
 * at the direct output and at the buffer head.
 * Assumes rse_encoder with default parameters and rse_sink.
 */
`timescale 1ns/1ps
`include "rse_defines.vh"
module tb_top;
    localparam int NB = `RSE_BLOCK_LEN;
    localparam int NC = 2 * `RSE_T;
    localparam int NM = NB - NC;
    logic       sys_clk, reset, clocken, load;
    logic [7:0] din, out_data, buf_data;
    logic       in_ready, out_valid, out_start, out_end;
    logic       buf_valid, buf_ready, buf_start, buf_end;
    logic [6:0] slow_pct;
    logic [9:0] exp_out[$];
    logic [9:0] exp_buf[$];
    logic [9:0] ew;
    logic [7:0] gen[0:NC];
    int         bad_count, num_checks, n;

    rse_encoder dut_u (
        .sys_clk(sys_clk), .reset(reset), .clocken(clocken),
        .load(load), .din(din), .in_ready(in_ready),
        .out_valid(out_valid), .out_start(out_start), .out_end(out_end),
        .out_data(out_data), .buf_valid(buf_valid), .buf_ready(buf_ready),
        .buf_start(buf_start), .buf_end(buf_end), .buf_data(buf_data));
    rse_sink sink_u (.sys_clk(sys_clk), .slow_pct(slow_pct),
        .buf_ready(buf_ready));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] gf_mul(input logic [7:0] a,
                                          input logic [7:0] b);
        logic [8:0] acc;
        logic [8:0] sh;
        acc = 9'h000;
        sh = {1'b0, a};
        for (int i = 0; i < 8; i++) begin
            if (b[i]) acc ^= sh;
            sh = sh << 1;
            if (sh[8]) sh ^= `RSE_PRIM_POLY;
        end
        return acc[7:0];
    endfunction

    task automatic cmp_word(input string what, input logic [9:0] exp,
                            input logic [9:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Retry one symbol until an enabled edge takes it
    task automatic put(input logic ld, input logic [7:0] d, input int stall);
        logic ce;
        logic taken;
        taken = 1'b0;
        while (!taken) begin
            ce = ($urandom % 100) >= stall;
            clocken <= ce;
            load <= ce ? ld : 1'($urandom);
            din <= ce ? d : 8'($urandom);
            @(posedge sys_clk);
            taken = clocken && in_ready;
        end
    endtask

    task automatic send_msg(input int stall, input int gap);
        logic [7:0] msg[$];
        logic [7:0] par[0:NC-1];
        logic [7:0] fb;
        logic [9:0] w;
        for (int i = 0; i < NM; i++) msg.push_back(8'($urandom));
        for (int j = 0; j < NC; j++) par[j] = 8'h00;
        for (int i = 0; i < NM; i++) begin
            fb = msg[i] ^ par[NC-1];
            for (int j = NC - 1; j > 0; j--)
                par[j] = par[j-1] ^ gf_mul(fb, gen[j]);
            par[0] = gf_mul(fb, gen[0]);
        end
        for (int i = 0; i < NB; i++) begin
            w = {i == 0, i == NB - 1, i < NM ? msg[i] : par[NB-1-i]};
            exp_out.push_back(w);
            exp_buf.push_back(w);
        end
        for (int i = 0; i < NM; i++) put(i == 0, msg[i], stall);
        for (int i = 0; i < gap; i++) put(1'b0, 8'($urandom), stall);
    endtask

    always @(posedge sys_clk) begin
        if (!reset && clocken && in_ready && out_valid) begin
            ew = exp_out.size() ? exp_out.pop_front() : 10'h3ff;
            cmp_word("out word", ew, {out_start, out_end, out_data});
        end
        if (!reset && buf_valid && buf_ready) begin
            ew = exp_buf.size() ? exp_buf.pop_front() : 10'h3ff;
            cmp_word("buf word", ew, {buf_start, buf_end, buf_data});
        end
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #300000;
        bad_count++;
        final_report;
    end

    initial begin
        void'($urandom(32'ha705));
        reset = 1'b1;
        clocken = 1'b1;
        load = 1'b0;
        din = 8'h00;
        slow_pct = 7'd0;
        // Generator with roots alpha^0 .. alpha^(2T-1)
        for (int j = 0; j <= NC; j++) gen[j] = 8'h00;
        gen[0] = 8'h01;
        fb_loop();
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (10) put(1'b0, 8'h00, 0);
        repeat (3) send_msg(0, NC);
        slow_pct <= 7'd50;
        send_msg(30, NC + 3);
        slow_pct <= 7'd95;
        send_msg(0, NC);
        slow_pct <= 7'd20;
        send_msg(10, NC);
        n = 0;
        while (exp_buf.size() != 0 && n < 20000) begin
            put(1'b0, 8'h00, 0);
            n++;
        end
        n = exp_out.size() + exp_buf.size();
        cmp_word("words left", 10'h000, 10'(n));
        final_report;
    end

    task automatic fb_loop;
        logic [7:0] root;
        root = 8'h01;
        for (int i = 0; i < NC; i++) begin
            for (int j = i + 1; j > 0; j--)
                gen[j] = gen[j-1] ^ gf_mul(gen[j], root);
            gen[0] = gf_mul(gen[0], root);
            root = gf_mul(root, 8'h02);
        end
    endtask
endmodule
